/* File: logic/sxd_core.sv */
/*
 Execution slice: decodes and runs nibble swap, XOR literal/file and the legacy
 direction load; keeps program counter, return stack, upper latch, pointer,
 prescaler config and three direction registers.
 Assumes an outside fetch unit presents one instruction per enable cycle and an
 outside file memory answers reads combinationally for addresses not held here.
*/
`timescale 1ns/10ps
module sxd_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Instruction and flow
    input sxd_pkg::sxd_insn_t insn_in,
    input sxd_pkg::sxd_flow_t flow_in,
    input wire logic [sxd_pkg::PC_W-1:0] call_target,
    // External file memory
    input wire logic [7:0] ext_rdata,
    output logic [sxd_pkg::FADDR_W-1:0] file_raddr,
    output sxd_pkg::sxd_fwr_t ext_wr,
    // State visible outside
    output logic [sxd_pkg::PC_W-1:0] pc,
    output logic [7:0] acc,
    output logic [7:0] status,
    output logic [7:0] ptr,
    output logic [7:0] presc_cfg,
    output logic [23:0] dir_regs,
    output logic [sxd_pkg::SP_W-1:0] stack_ptr
);
    import sxd_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [INSN_W-1:0] w;
    logic is_swap, is_xorf, is_xorl, is_dirl, dest_f;
    logic [FADDR_W-1:0] fa;
    logic [7:0] fval, result;
    logic [7:0] acc_r, status_r, ptr_r, presc_r, latch_r;
    logic [7:0] dir_r [3];
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [SP_W-1:0] sp_r;

    // Word layout: [13:8] opcode, [7] destination, [6:0] file address
    assign w = insn_in.word;
    assign is_swap = insn_in.valid && w[13:8] == OP_SWAP;
    assign is_xorf = insn_in.valid && w[13:8] == OP_XORF;
    assign is_xorl = insn_in.valid && w[13:8] == OP_XORL;
    assign is_dirl = insn_in.valid && w[13:3] == OP_DIRL
        && w[2:0] >= DIR_FIRST;
    assign dest_f = w[7];
    assign fa = w[6:0];
    assign file_raddr = fa;

    // Local registers answer reads; the rest come from file memory
    always_comb begin
        if (fa == FA_STATUS) begin
            fval = status_r;
        end else if (fa == FA_PTR) begin
            fval = ptr_r;
        end else if (fa == FA_LATCH) begin
            fval = latch_r;
        end else if (fa == FA_PCL) begin
            fval = pc_r[7:0];
        end else if (fa == FA_PRESC) begin
            fval = presc_r;
        end else if (fa >= FA_DIR_A && fa <= FA_DIR_C) begin
            fval = dir_r[fa[1:0] - 2'd1];
        end else begin
            fval = ext_rdata;
        end
    end

    // Every opcode but swap xors with the accumulator; unused results are dropped
    always_comb begin
        if (is_swap) begin
            result = {fval[3:0], fval[7:4]};
        end else if (is_xorl) begin
            result = acc_r ^ w[7:0];
        end else begin
            result = acc_r ^ fval;
        end
    end

    logic wr_file, wr_acc, wr_ext;
    assign wr_file = (is_swap || is_xorf) && dest_f;
    assign wr_acc = ((is_swap || is_xorf) && !dest_f) || is_xorl;
    // Addresses held in this slice never reach the outside memory
    assign wr_ext = wr_file && fa > FA_DIR_C && fa != FA_LATCH;

    // ------------------------------------------------------------
    // Accumulator and status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= BYTE_RST;
        end else if (wr_acc) begin
            acc_r <= result;
        end
    end

    // Swap leaves flags alone; an explicit write to status yields to the flag update
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= BYTE_RST;
        end else if (is_xorl || is_xorf) begin
            status_r[Z_BIT] <= (result == 8'h00);
        end else if (wr_file && fa == FA_STATUS) begin
            status_r <= result;
        end
    end

    // ------------------------------------------------------------
    // Pointer, upper latch, prescaler, direction registers
    // ------------------------------------------------------------
    // Pointer keeps all eight bits; nothing masks the top bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_r <= BYTE_RST;
        end else if (wr_file && fa == FA_PTR) begin
            ptr_r <= result;
        end
    end

    // Only five latch bits reach the counter; the top three are plain storage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_r <= BYTE_RST;
        end else if (wr_file && fa == FA_LATCH) begin
            latch_r <= result;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_r <= PRESC_RST;
        end else if (wr_file && fa == FA_PRESC) begin
            presc_r <= result;
        end
    end

    // Legacy load and direct file writes share one register per port
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_dir
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    dir_r[gi] <= DIR_RST;
                end else if (is_dirl && w[2:0] == DIR_FIRST + 3'(gi)) begin
                    dir_r[gi] <= acc_r;
                end else if (wr_file && fa == FA_DIR_A + 7'(gi)) begin
                    dir_r[gi] <= result;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Program counter and return stack
    // ------------------------------------------------------------
    logic [PC_W-1:0] pc_inc;
    assign pc_inc = pc_r + 13'd1;

    // Interrupt wins over call and return; writes to the low byte take the latch high bits
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_r <= RESET_VEC;
        end else if (flow_in.irq) begin
            pc_r <= IRQ_VEC;
        end else if (flow_in.ret) begin
            pc_r <= stack_r[sp_r - 3'd1];
        end else if (flow_in.call) begin
            pc_r <= call_target;
        end else if (wr_file && fa == FA_PCL) begin
            pc_r <= {latch_r[4:0], result};
        end else if (insn_in.valid) begin
            pc_r <= pc_inc;
        end
    end

    // Circular stack: overflow silently overwrites the oldest entry
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_r <= 3'd0;
        end else if (flow_in.irq || (flow_in.call && !flow_in.ret)) begin
            sp_r <= sp_r + 3'd1;
        end else if (flow_in.ret) begin
            sp_r <= sp_r - 3'd1;
        end
    end

    // No reset: an entry is only read after a push has filled it
    always_ff @(posedge ref_clk) begin
        if (flow_in.irq) begin
            stack_r[sp_r] <= pc_r;
        end else if (flow_in.call && !flow_in.ret) begin
            stack_r[sp_r] <= pc_inc;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_wr <= '0;
        end else begin
            ext_wr.we <= wr_ext;
            ext_wr.addr <= fa;
            ext_wr.data <= result;
        end
    end

    assign pc = pc_r;
    assign acc = acc_r;
    assign status = status_r;
    assign ptr = ptr_r;
    assign presc_cfg = presc_r;
    assign dir_regs = {dir_r[2], dir_r[1], dir_r[0]};
    assign stack_ptr = sp_r;
endmodule // sxd_core

/* File: logic/sxd_pkg.sv */
/*
 Package for the nibble-swap / exclusive-OR / direction-load execution slice.
 Assumes one instruction clock and an asynchronous active-low reset.
*/
// What this block does
// - Nibble swap exchanges upper and lower four bits; flags untouched; one cycle.
// - Swap and file XOR write accumulator when dest bit 0, file when 1.
// - Literal XOR: accumulator xor literal into accumulator, zero flag only, one cycle.
// - File XOR: accumulator xor file to chosen destination, zero flag only.
// - File operand of swap and XOR is a 7-bit address, 0 to 127.
// - Direction load copies accumulator into direction register 5 to 7, no flags.
// - Instruction words are 14 bits wide.
// - Accepted interrupt loads program counter with vector 0004h.
// - After reset, execution starts at program address 0000h.
// - Return-address stack is eight entries deep.
// - High program-counter bits come from separate upper latch register.
// - Indirect pointer is a full eight-bit register.
// - Prescaler config and direction registers are ordinary addressed file registers.
package sxd_pkg;
    localparam int INSN_W = 14;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
    // Opcode patterns
    localparam logic [5:0] OP_SWAP = 6'h0e;
    localparam logic [5:0] OP_XORF = 6'h06;
    localparam logic [5:0] OP_XORL = 6'h3a;
    localparam logic [10:0] OP_DIRL = 11'h00c;
    // File addresses held locally
    localparam logic [FADDR_W-1:0] FA_PCL = 7'h02;
    localparam logic [FADDR_W-1:0] FA_STATUS = 7'h03;
    localparam logic [FADDR_W-1:0] FA_PTR = 7'h04;
    localparam logic [FADDR_W-1:0] FA_LATCH = 7'h0a;
    localparam logic [FADDR_W-1:0] FA_PRESC = 7'h01;
    localparam logic [FADDR_W-1:0] FA_DIR_A = 7'h05;
    localparam logic [FADDR_W-1:0] FA_DIR_C = 7'h07;
    localparam logic [2:0] DIR_FIRST = 3'h5;
    localparam int Z_BIT = 2;
    localparam logic [7:0] PRESC_RST = 8'hff;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef struct packed {
        logic valid;
        logic [INSN_W-1:0] word;
    } sxd_insn_t;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [7:0] data;
    } sxd_fwr_t;

    typedef struct packed {
        logic call;
        logic ret;
        logic irq;
    } sxd_flow_t;
endpackage

/* File: testbench/sxd_checker.sv */
/* Port checker for sxd_core.
   Assumes one clock; outside file addresses are 20h-7Fh. */
`timescale 1ns/10ps
module sxd_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Watched ports
    input sxd_pkg::sxd_insn_t insn_in,
    input sxd_pkg::sxd_flow_t flow_in,
    input wire logic [7:0] ext_rdata,
    input sxd_pkg::sxd_fwr_t ext_wr,
    input wire logic [sxd_pkg::PC_W-1:0] pc,
    input wire logic [7:0] acc,
    input wire logic [7:0] status,
    input wire logic [23:0] dir_regs,
    input wire logic [sxd_pkg::SP_W-1:0] stack_ptr
);
    import sxd_pkg::*;
    // ----
    // Properties
    // ----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic go;
    logic ext;
    logic [5:0] op;
    assign op = insn_in.word[13:8];
    assign go = insn_in.valid && flow_in == 3'h0;
    // Local addresses sit below 20h
    assign ext = insn_in.word[6:5] != 2'h0;
    property p_xl; go && op == OP_XORL |=> acc == ($past(acc) ^ $past(insn_in.word[7:0])); endproperty
    a_xl: assert property (p_xl) else $error("literal xor wrong");
    property p_z; go && op == OP_XORL |=> status[Z_BIT] == (acc == 8'h00); endproperty
    a_z: assert property (p_z) else $error("zero flag wrong");
    property p_sw; go && ext && op == OP_SWAP && !insn_in.word[7]
        |=> acc == {$past(ext_rdata[3:0]), $past(ext_rdata[7:4])} && $stable(status); endproperty
    a_sw: assert property (p_sw) else $error("swap wrong");
    property p_xf; go && ext && op == OP_XORF && insn_in.word[7]
        |=> ext_wr.we && ext_wr.data == ($past(acc) ^ $past(ext_rdata)) && $stable(acc); endproperty
    a_xf: assert property (p_xf) else $error("file xor wrong");
    property p_wa; go && ext && op == OP_SWAP && insn_in.word[7]
        |=> ext_wr.we && ext_wr.addr == $past(insn_in.word[6:0]); endproperty
    a_wa: assert property (p_wa) else $error("write address wrong");
    property p_dl; go && insn_in.word == 14'h0066 |=> dir_regs[15:8] == $past(acc) && $stable(status);
    endproperty
    a_dl: assert property (p_dl) else $error("direction load wrong");
    property p_iq; flow_in.irq |=> pc == IRQ_VEC && stack_ptr == $past(stack_ptr) + 3'h1; endproperty
    a_iq: assert property (p_iq) else $error("interrupt entry wrong");
    property p_rs; $rose(arst_n) |-> pc == RESET_VEC; endproperty
    a_rs: assert property (p_rs) else $error("reset address wrong");
endmodule // sxd_checker
bind sxd_core sxd_checker i_chk (.ref_clk, .arst_n, .insn_in, .flow_in, .ext_rdata, .ext_wr, .pc,
    .acc, .status, .dir_regs, .stack_ptr);

/* File: testbench/tb.sv */
/* Random xor, swap, direction-load and flow traffic for sxd_core.
   Assumes outside addresses 20h-7Fh answer on ext_rdata. */
`timescale 1ns/10ps
module tb;
    import sxd_pkg::*;
    // ----
    // Stimulus and model
    // ----
    logic ref_clk = 0;
    logic arst_n = 0;
    sxd_insn_t insn_in = '0;
    sxd_flow_t flow_in = '0;
    logic [7:0] ext_rdata = 8'h00;
    logic [PC_W-1:0] call_target = 13'h0123;
    sxd_fwr_t ext_wr;
    logic [PC_W-1:0] pc, m_pc = 13'h0000;
    logic [PC_W-1:0] stk [8];
    logic [7:0] acc, status, m_acc = 8'h00;
    logic [23:0] dir_regs, m_dir = 24'hffffff;
    logic [SP_W-1:0] stack_ptr, m_sp = 3'h0;
    logic [7:0] ptr, presc_cfg, m_ptr = 8'h00, m_presc = 8'hff, m_latch = 8'h00;
    logic [FADDR_W-1:0] file_raddr, m_fa = 7'h00;
    logic m_z = 0;
    logic taken = 0;
    logic [31:0] seed = 27117;
    logic [79:0] notes [$];
    logic [14:0] wnotes [$];
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    sxd_core i_sxd_core (.ref_clk(ref_clk), .arst_n(arst_n), .insn_in(insn_in), .flow_in(flow_in),
        .call_target(call_target), .ext_rdata(ext_rdata), .file_raddr(file_raddr),
        .ext_wr(ext_wr), .pc(pc), .acc(acc), .status(status), .ptr(ptr),
        .presc_cfg(presc_cfg), .dir_regs(dir_regs),
        .stack_ptr(stack_ptr));
    always #5 ref_clk = ~ref_clk;
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [79:0] model_word();
        return {m_acc, 5'h00, m_z, 2'h0, m_dir, m_pc, m_sp, m_ptr, m_presc, 1'b0, m_fa};
    endfunction
    function automatic logic [79:0] seen_word();
        return {acc, status, dir_regs, pc, stack_ptr, ptr, presc_cfg, 1'b0, file_raddr};
    endfunction
    task automatic cmp(input logic [79:0] e, input logic [79:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_wr(input logic [14:0] e, input logic [14:0] g);
        cmp({65'h0, e}, {65'h0, g});
    endtask
    task automatic note();
        notes.push_back(model_word());
    endtask
    task automatic run(input logic [13:0] w, input logic [7:0] rd);
        insn_in <= {1'b1, w};
        flow_in <= '0;
        ext_rdata <= rd;
        m_pc = m_pc + 13'h1;
        m_fa = w[6:0];
        note();
        @(negedge ref_clk);
    endtask
    task automatic pulse(input logic irq);
        insn_in <= '0;
        flow_in <= {1'b0, !irq, irq};
        m_fa = 7'h00;
        if (irq) begin
            stk[m_sp] = m_pc;
            m_sp++;
            m_pc = IRQ_VEC;
        end else begin
            m_sp--;
            m_pc = stk[m_sp];
        end
        note();
        @(negedge ref_clk);
    endtask
    task automatic put(input logic d, input logic [6:0] a, input logic [7:0] v);
        if (d) wnotes.push_back({a, v});
        else m_acc = v;
    endtask
    task automatic call_ret();
        logic [31:0] r;
        r = rnd();
        insn_in <= '0;
        flow_in <= 3'b100;
        call_target <= r[12:0];
        stk[m_sp] = m_pc + 13'h1;
        m_sp++;
        m_pc = r[12:0];
        m_fa = 7'h00;
        note();
        @(negedge ref_clk);
        pulse(1'b0);
    endtask
    task automatic set_acc(input logic [7:0] v);
        logic [7:0] k;
        k = m_acc ^ v;
        m_acc = v;
        m_z = v == 8'h00;
        run({OP_XORL, k}, 8'h00);
    endtask
    task automatic local_ops();
        logic [7:0] v;
        set_acc(8'hc3);
        m_ptr = m_ptr ^ m_acc;
        m_z = m_ptr == 8'h00;
        run({OP_XORF, 1'b1, FA_PTR}, 8'h00);
        m_presc = m_presc ^ m_acc;
        m_z = m_presc == 8'h00;
        run({OP_XORF, 1'b1, FA_PRESC}, 8'h00);
        // Direct write in place of the legacy direction load
        m_dir[7:0] = m_dir[7:0] ^ m_acc;
        m_z = m_dir[7:0] == 8'h00;
        run({OP_XORF, 1'b1, FA_DIR_A}, 8'h00);
        m_acc = m_acc ^ m_dir[15:8];
        m_z = m_acc == 8'h00;
        run({OP_XORF, 1'b0, FA_DIR_A + 7'h1}, 8'h00);
        m_acc = {m_presc[3:0], m_presc[7:4]};
        run({OP_SWAP, 1'b0, FA_PRESC}, 8'h00);
        v = m_acc ^ {5'h00, m_z, 2'h0};
        m_z = v == 8'h00;
        run({OP_XORF, 1'b1, FA_STATUS}, 8'h00);
        set_acc(8'h1e);
        m_latch = m_latch ^ m_acc;
        m_z = m_latch == 8'h00;
        run({OP_XORF, 1'b1, FA_LATCH}, 8'h00);
        v = m_acc ^ m_pc[7:0];
        m_z = v == 8'h00;
        // Run adds one, so aim one short of the paged target
        m_pc = {m_latch[4:0], v} - 13'h1;
        run({OP_XORF, 1'b1, FA_PCL}, 8'h00);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        insn_in <= '0;
        flow_in <= '0;
        repeat (4) @(negedge ref_clk);
        arst_n <= 1'b1;
        m_acc = BYTE_RST;
        m_z = 1'b0;
        m_dir = {3{DIR_RST}};
        m_pc = RESET_VEC;
        m_sp = 3'h0;
        m_ptr = BYTE_RST;
        m_presc = PRESC_RST;
        m_latch = BYTE_RST;
        m_fa = 7'h00;
        cmp(model_word(), seen_word());
    endtask
    task automatic burst(input int n);
        logic [31:0] r;
        logic [7:0] f;
        logic [7:0] k;
        logic [6:0] a;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            a = r[6:0] | 7'h20;
            f = r[23:16];
            // Literal equal to acc forces a zero result
            k = r[27] ? m_acc : r[15:8];
            case (r[26:25])
                2'h0: begin
                    m_acc = m_acc ^ k;
                    m_z = m_acc == 8'h00;
                    run({OP_XORL, k}, f);
                end
                2'h1: begin
                    m_z = (m_acc ^ f) == 8'h00;
                    put(r[24], a, m_acc ^ f);
                    run({OP_XORF, r[24], a}, f);
                end
                2'h2: begin
                    put(r[24], a, {f[3:0], f[7:4]});
                    run({OP_SWAP, r[24], a}, f);
                end
                default: begin
                    if (r[2:0] >= 3'h5) m_dir[8*(int'(r[2:0])-5) +: 8] = m_acc;
                    run({OP_DIRL, r[2:0]}, f);
                end
            endcase
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        taken <= insn_in.valid | flow_in.irq | flow_in.ret | flow_in.call;
        cyc++;
        if (cyc == 2000) begin
            errors++;
            give_verdict();
        end
    end
    always @(negedge ref_clk) begin
        if (taken) cmp(notes.pop_front(), seen_word());
        if (ext_wr.we === 1'b1) cmp_wr(wnotes.pop_front(), {ext_wr.addr, ext_wr.data});
    end
    initial begin
        do_reset();
        burst(200);
        $display("test random ops done");
        repeat (8) pulse(1'b1);
        repeat (8) pulse(1'b0);
        call_ret();
        $display("test stack done");
        local_ops();
        $display("test local registers done");
        do_reset();
        $display("test mid-run reset done");
        burst(200);
        insn_in <= '0;
        flow_in <= '0;
        repeat (2) @(negedge ref_clk);
        cmp_wr(15'(wnotes.size()), 15'h0);
        $display("test random ops again done");
        give_verdict();
    end
endmodule // tb
